// ==== logic/oss_pkg.sv ====
// Function
// - Chip select high: ignore clock, float data out
// - Chip select rise latches shift register to outputs
// - Chip select fall loads fault status
// - Data out driven while chip select low
// - Controller keeps clock low at select edges
// - Sample data in on clock fall
// - Advance and present bit on clock rise
// - One means on, applied at select rise
// - Controller sends output eight bit first
// - Eight-bit shift register, eight falls fill
// - Controller parks clock low when idle
// - Controller keeps data stable at clock fall
// - Fault must persist 100 to 300 us
// - Controller spaces accesses over 300 us; the host takes a new start as soon as it returns to idle
// - Controller clock at most 6 MHz
// - Status one for faulted, zero normal
// - First rise presents output eight status
// - Outputs five, six ORed with direct inputs
// - Enable low: outputs off, detection suspended
`default_nettype none
package oss_pkg;
  // ==========================================
  // Sizes and timing
  localparam int WORD_BITS = 8;
  localparam int CLK_MHZ = 50;
  localparam int FAULT_QUALIFY_MIN_US = 100;
  localparam int FAULT_QUALIFY_MAX_US = 300;
  // Between min and max so the window holds with margin
  localparam int FAULT_QUALIFY_US = 150;
  localparam int FAULT_QUALIFY_CYCLES = FAULT_QUALIFY_US * CLK_MHZ;
  localparam int ACCESS_SPACING_US = 300;
  localparam int SCLK_MAX_KHZ = 6000;
  localparam int SCLK_TYP_KHZ = 4000;
  // Host divider: half period in core cycles, 50/(2*5) = 5 MHz
  localparam int HOST_HALF_CYCLES = 5;
  localparam int HOST_GAP_CYCLES = 8;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
endpackage
`default_nettype wire

// ==== logic/oss_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface oss_if;
  logic cs_n;
  logic sclk;
  logic serial_data_in;
  logic sdo_out;
  logic sdo_oe;
  wire logic sdo_line;
  // Released line reads low; host only samples it inside a frame
  assign sdo_line = sdo_oe ? sdo_out : 1'b0;
  modport dev (input cs_n, input sclk, input serial_data_in, output sdo_out, output sdo_oe);
  modport host (output cs_n, output sclk, output serial_data_in, input sdo_line);
endinterface
`default_nettype wire

// ==== logic/oss_device.sv ====
`timescale 1ns/10ps
`default_nettype none
module oss_device #(
  parameter int FAULT_CYCLES = oss_pkg::FAULT_QUALIFY_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  oss_if.dev spi,
  input wire logic enable,
  input wire logic direct_drive_input_five,
  input wire logic direct_drive_input_six,
  input wire logic [7:0] fault_raw,
  output logic [7:0] out_on
);
  // ==========================================
  // Three-stage pin synchronisers
  // Select idles high so no false fall follows reset
  logic cs_lvl, cs_fall, cs_rise, sck_fall, sck_rise;
  logic en_q, di_q, in5_q, in6_q;

  oss_sync #(
    .RESET_VAL(1'b1)
  ) u_oss_sync_cs (
    .core_clk(core_clk),
    .rst(rst),
    .pin(spi.cs_n),
    .level(cs_lvl),
    .rise(cs_rise),
    .fall(cs_fall)
  );

  oss_sync #(
    .RESET_VAL(1'b0)
  ) u_oss_sync_sck (
    .core_clk(core_clk),
    .rst(rst),
    .pin(spi.sclk),
    .level(),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  // Data lags the clock edge detector, so the bit before the fall is taken
  oss_sync #(
    .RESET_VAL(1'b0)
  ) u_oss_sync_di (
    .core_clk(core_clk),
    .rst(rst),
    .pin(spi.serial_data_in),
    .level(di_q),
    .rise(),
    .fall()
  );

  oss_sync #(
    .RESET_VAL(1'b0)
  ) u_oss_sync_en (
    .core_clk(core_clk),
    .rst(rst),
    .pin(enable),
    .level(en_q),
    .rise(),
    .fall()
  );

  oss_sync #(
    .RESET_VAL(1'b0)
  ) u_oss_sync_in5 (
    .core_clk(core_clk),
    .rst(rst),
    .pin(direct_drive_input_five),
    .level(in5_q),
    .rise(),
    .fall()
  );

  oss_sync #(
    .RESET_VAL(1'b0)
  ) u_oss_sync_in6 (
    .core_clk(core_clk),
    .rst(rst),
    .pin(direct_drive_input_six),
    .level(in6_q),
    .rise(),
    .fall()
  );

  // ==========================================
  // Fault qualification per output
  logic [7:0] status_reg, status_next;
  logic [31:0] fcnt_reg [8];
  logic [31:0] fcnt_next [8];
  always_comb begin
    status_next = status_reg;
    for (int i = 0; i < 8; i++) begin
      fcnt_next[i] = fcnt_reg[i];
      if (!en_q || !fault_raw[i]) begin
        fcnt_next[i] = 32'h0;
        if (en_q) begin
          status_next[i] = 1'b0;
        end
      end else if (fcnt_reg[i] >= 32'(FAULT_CYCLES - 1)) begin
        status_next[i] = 1'b1;
      end else begin
        fcnt_next[i] = fcnt_reg[i] + 32'h1;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        fcnt_reg[i] <= 32'h0;
      end
    end else begin
      status_reg <= status_next;
      fcnt_reg <= fcnt_next;
    end
  end

  // ==========================================
  // Shift register, latch, data out
  logic [7:0] shift_reg, shift_next, latch_reg, latch_next, out_reg, out_next;
  logic sdo_reg, sdo_next, oe_reg, oe_next;
  always_comb begin
    shift_next = shift_reg;
    latch_next = latch_reg;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    if (cs_fall) begin
      shift_next = status_reg;
      oe_next = 1'b1;
      sdo_next = status_reg[7];
    end else if (cs_rise) begin
      latch_next = shift_reg;
      oe_next = 1'b0;
    end else if (!cs_lvl) begin
      // Bit 7 is on the pin; rise moves the next bit out, fall takes data in
      if (sck_rise) begin
        sdo_next = shift_reg[7];
      end
      if (sck_fall) begin
        shift_next = {shift_reg[6:0], di_q};
      end
    end
    out_next = en_q ? latch_reg : 8'h00;
    out_next[4] = en_q & (latch_reg[4] | in5_q);
    out_next[5] = en_q & (latch_reg[5] | in6_q);
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_reg <= oss_pkg::SHIFT_RESET;
      latch_reg <= oss_pkg::LATCH_RESET;
      out_reg <= 8'h00;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      latch_reg <= latch_next;
      out_reg <= out_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
    end
  end
  assign spi.sdo_out = sdo_reg;
  assign spi.sdo_oe = oe_reg;
  assign out_on = out_reg;
endmodule

// ==========================================
// Pin synchroniser with agreement filter
// A level change counts only once stages two and three agree,
// which rejects a single-cycle glitch at the cost of one cycle.
module oss_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic [2:0] s_reg, s_next;
  logic q_reg, q_next;
  always_comb begin
    s_next = {s_reg[1:0], pin};
    q_next = (s_reg[1] == s_reg[2]) ? s_reg[2] : q_reg;
    rise = ~q_reg & q_next;
    fall = q_reg & ~q_next;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= {3{RESET_VAL}};
      q_reg <= RESET_VAL;
    end else begin
      s_reg <= s_next;
      q_reg <= q_next;
    end
  end
  assign level = q_reg;
endmodule
`default_nettype wire

// ==== logic/oss_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module oss_host (
  input wire logic core_clk,
  input wire logic rst,
  oss_if.host spi,
  input wire logic start,
  input wire logic [7:0] cmd,
  output logic busy,
  output logic done,
  output logic [7:0] status
);
  typedef enum logic [3:0] {
    OSS_IDLE = 4'h1,
    OSS_LEAD = 4'h2,
    OSS_XFER = 4'h4,
    OSS_GAP = 4'h8
  } oss_state_t;
  oss_state_t st_reg, st_next;
  logic [7:0] tx_reg, tx_next, rx_reg, rx_next, stat_reg, stat_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] div_reg, div_next;
  logic cs_reg, cs_next, sck_reg, sck_next, di_reg, di_next, done_reg, done_next;
  logic busy_reg, busy_next;
  logic [2:0] sdo_s_reg, sdo_s_next;
  logic tick;
  always_comb begin
    sdo_s_next = {sdo_s_reg[1:0], spi.sdo_line};
    st_next = st_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    stat_next = stat_reg;
    bit_next = bit_reg;
    cs_next = cs_reg;
    sck_next = sck_reg;
    di_next = di_reg;
    done_next = 1'b0;
    tick = (div_reg == 8'(oss_pkg::HOST_HALF_CYCLES - 1));
    div_next = tick ? 8'h00 : div_reg + 8'h01;
    case (st_reg)
      OSS_IDLE: begin
        div_next = 8'h00;
        sck_next = 1'b0;
        if (start) begin
          tx_next = cmd;
          cs_next = 1'b0;
          di_next = cmd[7];
          bit_next = 4'h0;
          st_next = OSS_LEAD;
        end
      end
      OSS_LEAD: begin
        if (tick) begin
          st_next = OSS_XFER;
        end
      end
      OSS_XFER: begin
        if (tick) begin
          if (!sck_reg) begin
            sck_next = 1'b1;
          end else begin
            // Device samples at our falling edge; data changes only after it
            sck_next = 1'b0;
            tx_next = {tx_reg[6:0], 1'b0};
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'h7) begin
              st_next = OSS_GAP;
            end
          end
        end else if (!sck_reg && div_reg == 8'h01 && bit_reg != 4'h0) begin
          di_next = tx_reg[7];
        end else if (!sck_reg && div_reg == 8'h03 && bit_reg != 4'h0) begin
          // Both pin paths add delay; the bit shown at the rise lands mid low phase
          rx_next = {rx_reg[6:0], sdo_s_reg[2]};
        end
      end
      OSS_GAP: begin
        if (!tick && div_reg == 8'h03 && bit_reg == 4'h8) begin
          rx_next = {rx_reg[6:0], sdo_s_reg[2]};
        end
        if (tick) begin
          bit_next = bit_reg + 4'h1;
          if (bit_reg == 4'h8) begin
            cs_next = 1'b1;
          end
          if (bit_reg == 4'(oss_pkg::HOST_GAP_CYCLES)) begin
            stat_next = rx_reg;
            done_next = 1'b1;
            st_next = OSS_IDLE;
          end
        end
      end
      default: begin
        st_next = OSS_IDLE;
      end
    endcase
    busy_next = (st_next != OSS_IDLE);
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= OSS_IDLE;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      stat_reg <= 8'h00;
      bit_reg <= 4'h0;
      div_reg <= 8'h00;
      cs_reg <= 1'b1;
      sck_reg <= 1'b0;
      di_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      sdo_s_reg <= 3'h0;
    end else begin
      st_reg <= st_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      stat_reg <= stat_next;
      bit_reg <= bit_next;
      div_reg <= div_next;
      cs_reg <= cs_next;
      sck_reg <= sck_next;
      di_reg <= di_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
      sdo_s_reg <= sdo_s_next;
    end
  end
  assign spi.cs_n = cs_reg;
  assign spi.sclk = sck_reg;
  assign spi.serial_data_in = di_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign status = stat_reg;
endmodule
`default_nettype wire

// ==== verification/oss_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module oss_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic sdo_out,
  input wire logic sdo_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic sclk_reg;
  logic [3:0] fall_cnt_reg;
  logic [3:0] fall_cnt_next;
  // ====================
  // Falls seen in frame
  always_comb begin
    fall_cnt_next = fall_cnt_reg;
    if (cs_n) begin
      fall_cnt_next = 4'h0;
    end else if (sclk_reg && !sclk) begin
      fall_cnt_next = fall_cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    sclk_reg <= sclk;
    fall_cnt_reg <= rst ? 4'h0 : fall_cnt_next;
  end
  // ====================
  // Properties
  property p_oe_on;
    $fell(cs_n) |-> ##[1:6] sdo_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("driver late after select");
  property p_oe_hold;
    !cs_n [*6] |-> sdo_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("driver off in frame");
  property p_oe_off;
    $rose(cs_n) |-> ##[1:6] !sdo_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driver on after frame");
  property p_edge_low;
    $changed(cs_n) |-> !sclk;
  endproperty
  a_edge_low: assert property (p_edge_low) else $error("clock high at select edge");
  property p_idle;
    cs_n |-> !sclk;
  endproperty
  a_idle: assert property (p_idle) else $error("clock not parked");
  property p_di_stable;
    $fell(sclk) |-> $stable(serial_data_in);
  endproperty
  a_di_stable: assert property (p_di_stable) else $error("data moved at fall");
  property p_half;
    $rose(sclk) |=> sclk [*4] ##1 !sclk;
  endproperty
  a_half: assert property (p_half) else $error("clock high time wrong");
  property p_lead;
    $fell(cs_n) |-> !sclk [*5];
  endproperty
  a_lead: assert property (p_lead) else $error("lead time short");
  property p_frame;
    $rose(cs_n) |-> fall_cnt_reg == 4'h8;
  endproperty
  a_frame: assert property (p_frame) else $error("frame not eight bits");
  c_frame: cover property ($rose(cs_n));
  c_shift: cover property ($rose(sclk) && sdo_oe);
  c_one: cover property (sdo_oe && sdo_out);
endmodule
`default_nettype wire

// ==== verification/octal_switch_serial_ctrl_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module octal_switch_serial_ctrl_tb;
  typedef struct packed {logic [7:0] st; logic [7:0] on;} oss_exp_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic enable = 1'b1;
  logic dd5 = 1'b0;
  logic dd6 = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] fault_raw = 8'h00;
  logic busy;
  logic done;
  logic [7:0] status;
  logic [7:0] out_on;
  logic [31:0] seed = 32'h28E8;
  int error_cnt = 0;
  int total_checks = 0;
  oss_exp_t exp_q[$];
  always #10 core_clk = ~core_clk;
  oss_if spi ();
  oss_host u_oss_host (.core_clk(core_clk), .rst(rst), .spi(spi.host), .start(start), .cmd(cmd),
    .busy(busy), .done(done), .status(status));
  // Short qualify count keeps the run brief
  oss_device #(.FAULT_CYCLES(20)) u_oss_device (.core_clk(core_clk), .rst(rst), .spi(spi.dev),
    .enable(enable), .direct_drive_input_five(dd5), .direct_drive_input_six(dd6),
    .fault_raw(fault_raw), .out_on(out_on));
  oss_assertions u_oss_assertions (.core_clk(core_clk), .rst(rst), .cs_n(spi.cs_n), .sclk(spi.sclk),
    .serial_data_in(spi.serial_data_in), .sdo_out(spi.sdo_out), .sdo_oe(spi.sdo_oe));
  // ====================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("FAIL %0t got %h want %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] c, input logic [7:0] st);
    int n;
    exp_q.push_back({st, (c | {2'h0, dd6, dd5, 4'h0}) & {8{enable}}});
    @(negedge core_clk);
    cmd = c;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 400) begin
      error_cnt++;
      test_done();
    end
    repeat (15) @(negedge core_clk);
  endtask
  // ====================
  // Result watcher
  initial begin
    oss_exp_t e;
    forever begin
      @(posedge done);
      #1;
      e = exp_q.pop_front();
      check(status, e.st);
      repeat (10) @(negedge core_clk);
      check(out_on, e.on);
    end
  end
  // ====================
  // Main sequence
  initial begin
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check(out_on, 8'h00);
    xfer(8'hA5, 8'h00);
    $display("test reset done");
    // Fault younger than the qualify count
    fault_raw = 8'h81;
    xfer(8'h3C, 8'h00);
    xfer(8'hC3, 8'h81);
    $display("test fault delay done");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      {dd6, dd5} = seed[9:8];
      fault_raw = seed[7:0];
      repeat (30) @(negedge core_clk);
      xfer(seed[23:16], seed[7:0]);
    end
    $display("test random done");
    // Status frozen and outputs dark while disabled
    enable = 1'b0;
    xfer(8'hFF, seed[7:0]);
    enable = 1'b1;
    repeat (8) @(negedge core_clk);
    check(out_on, 8'hFF);
    $display("test enable done");
    test_done();
  end
endmodule
`default_nettype wire
